// ==== inc/lsfs_pkg.sv ====
// Constants, register map and state encoding of the load switch fault supervisor.
// Assumes a single 125 MHz system clock; all millisecond timing is counted in ticks.
package lsfs_pkg;

	// Clock and derived timing
	localparam int unsigned CLK_HZ = 32'h0773_5940;
	localparam int unsigned MS_PER_S = 32'h0000_03e8;
	localparam int unsigned US_PER_S = 32'h000f_4240;
	localparam int unsigned MS_TICK_CYCLES = CLK_HZ / MS_PER_S;

	// Soft-start ramp of the gate drive code
	localparam int unsigned GATE_WIDTH = 32'h0000_0008;
	localparam int unsigned SOFTSTART_US = 32'h0000_03e8;
	localparam int unsigned RAMP_STEP_CYCLES =
		(CLK_HZ / US_PER_S) * SOFTSTART_US / (32'h0000_0001 << GATE_WIDTH);

	// Millisecond delays, counted in 1 ms ticks
	localparam logic [7:0] SURGE_WINDOW_MS = 8'h80;
	localparam logic [7:0] SURGE_REARM_MS = 8'h80;
	localparam logic [7:0] UV_DETECT_MS = 8'h20;
	localparam logic [7:0] UV_RETRY_MS = 8'h80;
	localparam logic [7:0] FAULT_DELAY_MS = 8'h20;
	localparam logic [7:0] FAULT_DELAY_SURGE_MS = 8'h80;

	// Register map (byte addresses)
	localparam int unsigned AXI_ADDR_W = 32'h0000_0008;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_STATUS = 8'h08;
	localparam logic [7:0] REG_INT_MASK = 8'h0c;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register fields
	localparam int unsigned CTRL_SOFT_OFF_BIT = 32'h0000_0000;

	// Status register fields
	localparam int unsigned STAT_SWITCH_BIT = 32'h0000_0000;
	localparam int unsigned STAT_LIMITING_BIT = 32'h0000_0001;
	localparam int unsigned STAT_WINDOW_BIT = 32'h0000_0002;
	localparam int unsigned STAT_ARMED_BIT = 32'h0000_0003;
	localparam int unsigned STAT_THERMAL_BIT = 32'h0000_0004;
	localparam int unsigned STAT_LOCKOUT_BIT = 32'h0000_0005;
	localparam int unsigned STAT_FAULT_BIT = 32'h0000_0006;
	localparam int unsigned STAT_STATE_LSB = 32'h0000_0008;
	localparam int unsigned STAT_GATE_LSB = 32'h0000_0010;

	// Interrupt status and mask fields
	localparam int unsigned INT_LIMIT = 32'h0000_0000;
	localparam int unsigned INT_THERMAL = 32'h0000_0001;
	localparam int unsigned INT_UV = 32'h0000_0002;
	localparam int unsigned INT_FAULT = 32'h0000_0003;
	localparam int unsigned INT_LOCKOUT = 32'h0000_0004;
	localparam int unsigned INT_WIDTH = 32'h0000_0005;

	// Switch sequencing states
	typedef enum logic [1:0] {
		LSFS_OFF,
		LSFS_RAMP,
		LSFS_ON,
		LSFS_UV_RETRY
	} lsfs_sw_state_t;

endpackage

// ==== src/lsfs_tick_div.sv ====
// Free-running divider giving a one-cycle enable pulse every CYCLES clocks.
// Assumes one clock and a synchronous active-low reset.
module lsfs_tick_div #(
	parameter int unsigned CYCLES = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	output logic tick
);

	localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	typedef struct packed {
		logic [W-1:0] count;
		logic tick;
	} lsfs_div_t;

	lsfs_div_t s;
	lsfs_div_t next_s;

	always_comb begin
		next_s = s;
		if (s.count == LAST) begin
			next_s.count = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.count = s.count + 1'b1;
			next_s.tick = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule

// ==== src/lsfs_supervisor.sv ====
// Load switch fault supervisor: enable, soft-start, surge window, supply
// lockout, undervoltage retry, thermal shutdown and fault flag blanking,
// with an AXI4-Lite register slave and a level interrupt.
// Assumes comparator results arrive as raw levels from the analog front end
// and that the open-drain fault wire is resolved outside from FAULT_N_OE.
//
// Behaviour
// - Overcurrent starts limiting; it lasts until overload ends or thermal shutdown.
// - Surge variants open a 128 ms window with only the secondary limit.
// - Secondary overcurrent in the window clamps to secondary limit until window end.
// - Variants without surge allowance apply the normal limit at once.
// - Surge window re-arms after 128 ms out of limiting.
// - Below supply lockout the switch is off; enable and fault are ignored.
// - Input below adjustable threshold 32 ms while enabled disables the switch.
// - After undervoltage disable, re-enable after 128 ms; repeat while low.
// - Enable polarity is a build option, high-true or low-true.
// - Fault flag is active low, set on limiting or thermal shutdown.
// - Without surge allowance, fault asserts after 32 ms and releases 32 ms late.
// - With surge allowance, fault asserts at window end, releases 128 ms late.
// - Turn-on ramps the gate drive gradually to limit inrush.
// - Die temperature trip turns the switch off and raises the fault.
// - Switch resumes once the die cools, cycling while the overload lasts.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
module lsfs_supervisor #(
	parameter int unsigned TICK_CYCLES = lsfs_pkg::MS_TICK_CYCLES,
	parameter bit SURGE_VARIANT = 1'b1,
	parameter bit EN_ACTIVE_HIGH = 1'b1,
	parameter bit ADJ_UV_PRESENT = 1'b1
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic ENABLE_PIN,
	input wire logic OVER_CURRENT,
	input wire logic SECONDARY_OVER_CURRENT,
	input wire logic SUPPLY_LOCKOUT,
	input wire logic ADJUSTABLE_SUPPLY_MONITOR,
	input wire logic TEMP_TRIP,
	input wire logic TEMP_COOLED,
	input wire logic [lsfs_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [lsfs_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic SWITCH_ON,
	output logic [lsfs_pkg::GATE_WIDTH-1:0] GATE_DRIVE,
	output logic LIMITING,
	output logic SECONDARY_CURRENT_LIMIT,
	output logic FAULT_N_OUT,
	output logic FAULT_N_OE,
	output logic IRQ
);

	localparam logic [7:0] fault_delay =
		SURGE_VARIANT ? lsfs_pkg::FAULT_DELAY_SURGE_MS : lsfs_pkg::FAULT_DELAY_MS;
	localparam int unsigned IW = lsfs_pkg::INT_WIDTH;
	localparam int unsigned GW = lsfs_pkg::GATE_WIDTH;

	typedef struct packed {
		logic [1:0] en_sync;
		logic [1:0] oc_sync;
		logic [1:0] soc_sync;
		logic [1:0] lo_sync;
		logic [1:0] uv_sync;
		logic [1:0] trip_sync;
		logic [1:0] cool_sync;
		logic lo_prev;
		lsfs_pkg::lsfs_sw_state_t state;
		logic [7:0] uv_cnt;
		logic thermal;
		logic switch_on;
		logic [GW-1:0] gate;
		logic window;
		logic armed;
		logic sec_hold;
		logic [7:0] win_cnt;
		logic [7:0] rearm_cnt;
		logic limiting;
		logic lim_secondary;
		logic fault;
		logic [7:0] fault_cnt;
		logic fault_oe;
		logic fault_out;
		logic aw_rdy;
		logic w_rdy;
		logic aw_have;
		logic w_have;
		logic [lsfs_pkg::AXI_ADDR_W-1:0] awaddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic soft_off;
		logic [IW-1:0] int_status;
		logic [IW-1:0] int_mask;
		logic irq;
	} lsfs_state_t;

	lsfs_state_t s;
	lsfs_state_t next_s;

	logic ms_tick;
	logic ramp_tick;
	logic lockout;
	logic en_req;
	logic allowed;
	logic uv_low;
	logic oc;
	logic soc;
	logic fault_raw;
	logic [IW-1:0] events;
	logic [IW-1:0] w1c_clear;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;

	lsfs_tick_div #(.CYCLES(TICK_CYCLES)) u_ms_tick (
		.clock(CLOCK),
		.rst_n(RST_N),
		.tick(ms_tick)
	);

	lsfs_tick_div #(.CYCLES(lsfs_pkg::RAMP_STEP_CYCLES)) u_ramp_tick (
		.clock(CLOCK),
		.rst_n(RST_N),
		.tick(ramp_tick)
	);

	always_comb begin
		next_s = s;
		events = '0;
		w1c_clear = '0;
		rd_word = '0;
		rd_resp = lsfs_pkg::RESP_OKAY;

		// Two-stage synchronisers; only the second stage is used downstream
		next_s.en_sync = {s.en_sync[0], ENABLE_PIN};
		next_s.oc_sync = {s.oc_sync[0], OVER_CURRENT};
		next_s.soc_sync = {s.soc_sync[0], SECONDARY_OVER_CURRENT};
		next_s.lo_sync = {s.lo_sync[0], SUPPLY_LOCKOUT};
		next_s.uv_sync = {s.uv_sync[0], ADJUSTABLE_SUPPLY_MONITOR};
		next_s.trip_sync = {s.trip_sync[0], TEMP_TRIP};
		next_s.cool_sync = {s.cool_sync[0], TEMP_COOLED};
		next_s.lo_prev = s.lo_sync[1];

		lockout = s.lo_sync[1];
		en_req = (EN_ACTIVE_HIGH ? s.en_sync[1] : ~s.en_sync[1]) & ~s.soft_off;
		uv_low = ADJ_UV_PRESENT & s.uv_sync[1];

		// Thermal shutdown with hysteresis; trip dominates cool
		if (s.trip_sync[1]) begin
			next_s.thermal = 1'b1;
		end else if (s.cool_sync[1]) begin
			next_s.thermal = 1'b0;
		end

		allowed = en_req & ~lockout & ~s.thermal;

		// Switch sequencing
		unique case (s.state)
			lsfs_pkg::LSFS_OFF: begin
				next_s.uv_cnt = '0;
				next_s.gate = '0;
				if (allowed) begin
					next_s.state = lsfs_pkg::LSFS_RAMP;
				end
			end
			lsfs_pkg::LSFS_RAMP, lsfs_pkg::LSFS_ON: begin
				if (!allowed) begin
					next_s.state = lsfs_pkg::LSFS_OFF;
					next_s.gate = '0;
					next_s.uv_cnt = '0;
				end else begin
					if (ramp_tick && s.gate != '1) begin
						next_s.gate = s.gate + 1'b1;
					end
					if (s.state == lsfs_pkg::LSFS_RAMP && s.gate == '1) begin
						next_s.state = lsfs_pkg::LSFS_ON;
					end
					// Undervoltage must persist; any recovery restarts the count
					if (!uv_low) begin
						next_s.uv_cnt = '0;
					end else if (ms_tick) begin
						if (s.uv_cnt + 8'h01 == lsfs_pkg::UV_DETECT_MS) begin
							next_s.state = lsfs_pkg::LSFS_UV_RETRY;
							next_s.uv_cnt = '0;
							next_s.gate = '0;
						end else begin
							next_s.uv_cnt = s.uv_cnt + 8'h01;
						end
					end
				end
			end
			lsfs_pkg::LSFS_UV_RETRY: begin
				next_s.gate = '0;
				if (!allowed) begin
					next_s.state = lsfs_pkg::LSFS_OFF;
					next_s.uv_cnt = '0;
				end else if (ms_tick) begin
					if (s.uv_cnt + 8'h01 == lsfs_pkg::UV_RETRY_MS) begin
						next_s.state = lsfs_pkg::LSFS_RAMP;
						next_s.uv_cnt = '0;
					end else begin
						next_s.uv_cnt = s.uv_cnt + 8'h01;
					end
				end
			end
		endcase

		next_s.switch_on = (next_s.state == lsfs_pkg::LSFS_RAMP) ||
			(next_s.state == lsfs_pkg::LSFS_ON);

		oc = s.oc_sync[1] & s.switch_on;
		soc = s.soc_sync[1] & s.switch_on;

		// Surge window: opens at the first overcurrent while armed
		if (!SURGE_VARIANT) begin
			next_s.window = 1'b0;
			next_s.armed = 1'b0;
			next_s.sec_hold = 1'b0;
			next_s.win_cnt = '0;
			next_s.rearm_cnt = '0;
		end else begin
			if (s.window) begin
				if (soc) begin
					next_s.sec_hold = 1'b1;
				end
				if (ms_tick) begin
					if (s.win_cnt + 8'h01 == lsfs_pkg::SURGE_WINDOW_MS) begin
						next_s.window = 1'b0;
						next_s.sec_hold = 1'b0;
						next_s.win_cnt = '0;
					end else begin
						next_s.win_cnt = s.win_cnt + 8'h01;
					end
				end
			end else if (s.armed && oc) begin
				next_s.window = 1'b1;
				next_s.armed = 1'b0;
				next_s.win_cnt = '0;
				next_s.sec_hold = soc;
			end
			// Re-arm only after a clean stretch out of limiting
			if (!s.armed && !s.window) begin
				if (s.limiting) begin
					next_s.rearm_cnt = '0;
				end else if (ms_tick) begin
					if (s.rearm_cnt + 8'h01 == lsfs_pkg::SURGE_REARM_MS) begin
						next_s.armed = 1'b1;
						next_s.rearm_cnt = '0;
					end else begin
						next_s.rearm_cnt = s.rearm_cnt + 8'h01;
					end
				end
			end else begin
				next_s.rearm_cnt = '0;
			end
			// Window and its clamp end with the switch
			if (!s.switch_on) begin
				next_s.window = 1'b0;
				next_s.sec_hold = 1'b0;
				next_s.win_cnt = '0;
			end
		end

		// Limiting follows the comparator; thermal shutdown drops switch_on
		next_s.lim_secondary = next_s.window;
		next_s.limiting = next_s.switch_on & (next_s.window ?
			(next_s.sec_hold | s.soc_sync[1]) : s.oc_sync[1]);

		// Fault blanking: the raw condition must hold for the delay either way
		fault_raw = oc | s.thermal;
		if (lockout) begin
			next_s.fault = 1'b0;
			next_s.fault_cnt = '0;
		end else if (fault_raw == s.fault) begin
			next_s.fault_cnt = '0;
		end else if (ms_tick) begin
			if (s.fault_cnt + 8'h01 == fault_delay) begin
				next_s.fault = fault_raw;
				next_s.fault_cnt = '0;
			end else begin
				next_s.fault_cnt = s.fault_cnt + 8'h01;
			end
		end
		// Open drain: only ever pulls low, the line's high comes from outside
		next_s.fault_out = 1'b0;
		next_s.fault_oe = next_s.fault;

		// Write channel: address and data taken in either order
		if (S_AXI_AWVALID && s.aw_rdy) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s.w_rdy) begin
			next_s.w_have = 1'b1;
			next_s.wdata = S_AXI_WDATA[7:0];
			next_s.wstrb0 = S_AXI_WSTRB[0];
		end
		if (s.bvalid && S_AXI_BREADY) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_have && s.w_have) begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = lsfs_pkg::RESP_OKAY;
			case ({s.awaddr[lsfs_pkg::AXI_ADDR_W-1:2], 2'h0})
				lsfs_pkg::REG_CTRL: begin
					if (s.wstrb0) begin
						next_s.soft_off = s.wdata[lsfs_pkg::CTRL_SOFT_OFF_BIT];
					end
				end
				lsfs_pkg::REG_STATUS: begin
					next_s.bresp = lsfs_pkg::RESP_OKAY;
				end
				lsfs_pkg::REG_INT_STATUS: begin
					if (s.wstrb0) begin
						w1c_clear = s.wdata[IW-1:0];
					end
				end
				lsfs_pkg::REG_INT_MASK: begin
					if (s.wstrb0) begin
						next_s.int_mask = s.wdata[IW-1:0];
					end
				end
				default: begin
					next_s.bresp = lsfs_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_s.aw_rdy = ~next_s.aw_have & ~next_s.bvalid;
		next_s.w_rdy = ~next_s.w_have & ~next_s.bvalid;

		// Read channel: data captured at the address handshake
		unique case ({S_AXI_ARADDR[lsfs_pkg::AXI_ADDR_W-1:2], 2'h0})
			lsfs_pkg::REG_CTRL: begin
				rd_word[lsfs_pkg::CTRL_SOFT_OFF_BIT] = s.soft_off;
			end
			lsfs_pkg::REG_STATUS: begin
				rd_word[lsfs_pkg::STAT_SWITCH_BIT] = s.switch_on;
				rd_word[lsfs_pkg::STAT_LIMITING_BIT] = s.limiting;
				rd_word[lsfs_pkg::STAT_WINDOW_BIT] = s.window;
				rd_word[lsfs_pkg::STAT_ARMED_BIT] = s.armed;
				rd_word[lsfs_pkg::STAT_THERMAL_BIT] = s.thermal;
				rd_word[lsfs_pkg::STAT_LOCKOUT_BIT] = lockout;
				rd_word[lsfs_pkg::STAT_FAULT_BIT] = s.fault;
				rd_word[lsfs_pkg::STAT_STATE_LSB +: 2] = s.state;
				rd_word[lsfs_pkg::STAT_GATE_LSB +: GW] = s.gate;
			end
			lsfs_pkg::REG_INT_STATUS: begin
				rd_word[IW-1:0] = s.int_status;
			end
			lsfs_pkg::REG_INT_MASK: begin
				rd_word[IW-1:0] = s.int_mask;
			end
			default: begin
				rd_resp = lsfs_pkg::RESP_SLVERR;
			end
		endcase
		if (s.rvalid && S_AXI_RREADY) begin
			next_s.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && s.ar_rdy) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_word;
			next_s.rresp = rd_resp;
		end
		next_s.ar_rdy = ~next_s.rvalid;

		// Sticky events; a new event wins over a clear in the same cycle
		events[lsfs_pkg::INT_LIMIT] = next_s.limiting & ~s.limiting;
		events[lsfs_pkg::INT_THERMAL] = next_s.thermal & ~s.thermal;
		events[lsfs_pkg::INT_UV] = (next_s.state == lsfs_pkg::LSFS_UV_RETRY) &&
			(s.state != lsfs_pkg::LSFS_UV_RETRY);
		events[lsfs_pkg::INT_FAULT] = next_s.fault & ~s.fault;
		events[lsfs_pkg::INT_LOCKOUT] = s.lo_sync[1] & ~s.lo_prev;
		next_s.int_status = (s.int_status & ~w1c_clear) | events;
		next_s.irq = |(next_s.int_status & next_s.int_mask);
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			s <= '0;
			s.armed <= SURGE_VARIANT;
		end else begin
			s <= next_s;
		end
	end

	assign S_AXI_AWREADY = s.aw_rdy;
	assign S_AXI_WREADY = s.w_rdy;
	assign S_AXI_BRESP = s.bresp;
	assign S_AXI_BVALID = s.bvalid;
	assign S_AXI_ARREADY = s.ar_rdy;
	assign S_AXI_RDATA = s.rdata;
	assign S_AXI_RRESP = s.rresp;
	assign S_AXI_RVALID = s.rvalid;
	assign SWITCH_ON = s.switch_on;
	assign GATE_DRIVE = s.gate;
	assign LIMITING = s.limiting;
	assign SECONDARY_CURRENT_LIMIT = s.lim_secondary;
	assign FAULT_N_OUT = s.fault_out;
	assign FAULT_N_OE = s.fault_oe;
	assign IRQ = s.irq;

endmodule

// ==== tb/lsfs_supervisor_chk.sv ====
// Port-level checker for the load switch fault supervisor.
// Assumes it is bound to lsfs_supervisor and sees only that module's ports.
module lsfs_supervisor_chk #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic SUPPLY_LOCKOUT,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic SWITCH_ON,
	input wire logic [lsfs_pkg::GATE_WIDTH-1:0] GATE_DRIVE,
	input wire logic SECONDARY_CURRENT_LIMIT,
	input wire logic FAULT_N_OUT,
	input wire logic FAULT_N_OE
);
	timeunit 1ns;
	timeprecision 1ps;
	// Window may run up to one tick short because of the free-running tick phase; the bound keeps a tick spare
	localparam int WIN = 129 * TICK_CYCLES;
	int win_cnt;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	always_ff @(posedge CLOCK) begin
		win_cnt <= (!RST_N || !SECONDARY_CURRENT_LIMIT) ? 0 : win_cnt + 1;
	end
	a_lockout_off: assert property (SUPPLY_LOCKOUT [*4] |=> !SWITCH_ON && !FAULT_N_OE)
		else $error("switch or fault active in lockout");
	a_window_bound: assert property (win_cnt <= WIN)
		else $error("surge window too long");
	a_gate_off: assert property (!SWITCH_ON [*2] |-> GATE_DRIVE == 8'h00)
		else $error("gate drive while off");
	a_gate_step: assert property (SWITCH_ON && $changed(GATE_DRIVE)
		|-> GATE_DRIVE == $past(GATE_DRIVE) + 8'h01)
		else $error("gate drive jumped");
	a_fault_low: assert property (FAULT_N_OE |-> !FAULT_N_OUT)
		else $error("fault flag not driven low");
	a_rd_lat: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	a_wr_lat: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##2 S_AXI_BVALID)
		else $error("write answer late");
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read response changed");
	a_ready_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write accepted while response pending");
	c_window: cover property ($rose(SECONDARY_CURRENT_LIMIT));
	c_fault: cover property ($rose(FAULT_N_OE));
	c_off: cover property ($fell(SWITCH_ON) && !SUPPLY_LOCKOUT);
endmodule

bind lsfs_supervisor lsfs_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_lsfs_supervisor_chk (
	.CLOCK(CLOCK), .RST_N(RST_N), .SUPPLY_LOCKOUT(SUPPLY_LOCKOUT),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.SWITCH_ON(SWITCH_ON), .GATE_DRIVE(GATE_DRIVE),
	.SECONDARY_CURRENT_LIMIT(SECONDARY_CURRENT_LIMIT),
	.FAULT_N_OUT(FAULT_N_OUT), .FAULT_N_OE(FAULT_N_OE));

// ==== tb/lsfs_host_model.sv ====
// Host side of the switch: drives the enable pin, resolves the fault wire.
// Assumes the shared fault wire has one pull-up and may carry another source.
module lsfs_host_model #(
	parameter bit EN_ACTIVE_HIGH = 1'b1
) (
	input wire logic want_on,
	input wire logic fault_oe,
	input wire logic fault_out,
	input wire logic other_oe,
	output logic enable_pin,
	output logic fault_line
);
	timeunit 1ns;
	timeprecision 1ps;
	assign enable_pin = EN_ACTIVE_HIGH ? want_on : !want_on;
	// Pull-up wins unless some party pulls the shared line low
	assign fault_line = !((fault_oe && !fault_out) || other_oe);
endmodule

// ==== tb/lsfs_supervisor_tb_top.sv ====
// Self-checking bench for the load switch fault supervisor.
// Assumes a short millisecond tick of T cycles so every delay stays brief.
module lsfs_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T = 10;
	logic clock, rst_n, want_on, other_oe, en, oc, oc2, lock, uv, trip, cool;
	logic awv, wv, bready, arv, rready, awr, wrdy, bv, arr, rv;
	logic sw, lim, sec, fout, foe, irq, fline;
	logic [7:0] awaddr, araddr, gate;
	logic [31:0] wdata, rdata, d, m;
	logic [1:0] bresp, rresp, r;
	int errors, checks, n, s;
	int cyc = 0;
	logic en_lo, sw_lo, lim_lo, sec_lo, foe_lo;

	lsfs_supervisor #(.TICK_CYCLES(T)) u_lsfs_supervisor (
		.CLOCK(clock), .RST_N(rst_n), .ENABLE_PIN(en), .OVER_CURRENT(oc),
		.SECONDARY_OVER_CURRENT(oc2), .SUPPLY_LOCKOUT(lock),
		.ADJUSTABLE_SUPPLY_MONITOR(uv), .TEMP_TRIP(trip), .TEMP_COOLED(cool),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
		.SWITCH_ON(sw), .GATE_DRIVE(gate), .LIMITING(lim), .SECONDARY_CURRENT_LIMIT(sec),
		.FAULT_N_OUT(fout), .FAULT_N_OE(foe), .IRQ(irq));
	lsfs_host_model u_lsfs_host_model (.want_on(want_on), .fault_oe(foe),
		.fault_out(fout), .other_oe(other_oe), .enable_pin(en), .fault_line(fline));
	// Variant without surge allowance and with a low-true enable, on the same stimulus
	lsfs_supervisor #(.TICK_CYCLES(T), .SURGE_VARIANT(1'b0), .EN_ACTIVE_HIGH(1'b0))
		u_lsfs_supervisor_lo (
		.CLOCK(clock), .RST_N(rst_n), .ENABLE_PIN(en_lo), .OVER_CURRENT(oc),
		.SECONDARY_OVER_CURRENT(oc2), .SUPPLY_LOCKOUT(lock),
		.ADJUSTABLE_SUPPLY_MONITOR(uv), .TEMP_TRIP(trip), .TEMP_COOLED(cool),
		.S_AXI_AWADDR(8'h00), .S_AXI_AWVALID(1'b0), .S_AXI_AWREADY(), .S_AXI_WDATA(32'h0),
		.S_AXI_WSTRB(4'h0), .S_AXI_WVALID(1'b0), .S_AXI_WREADY(), .S_AXI_BRESP(),
		.S_AXI_BVALID(), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(8'h00), .S_AXI_ARVALID(1'b0),
		.S_AXI_ARREADY(), .S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(),
		.S_AXI_RREADY(1'b1), .SWITCH_ON(sw_lo), .GATE_DRIVE(), .LIMITING(lim_lo),
		.SECONDARY_CURRENT_LIMIT(sec_lo), .FAULT_N_OUT(), .FAULT_N_OE(foe_lo), .IRQ());
	lsfs_host_model #(.EN_ACTIVE_HIGH(1'b0)) u_lsfs_host_model_lo (.want_on(want_on),
		.fault_oe(foe_lo), .fault_out(1'b0), .other_oe(1'b0), .enable_pin(en_lo),
		.fault_line());

	initial begin
		clock = 1'b0;
		forever #4 clock = !clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	function automatic int ms(input int k);
		return k * T;
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return sw;
			1: return sec;
			2: return foe;
			default: return lim;
		endcase
	endfunction
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int k, input logic v, input int lim_n);
		n = 0;
		while (sig(k) !== v && n < lim_n) begin
			@(posedge clock);
			n++;
		end
		if (n >= lim_n) begin
			errors++;
			$display("ERROR wait on %0d expected %b seen %b", k, v, sig(k));
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		awaddr <= a;
		wdata <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (!bv && i < 200);
		r = bresp;
		if (i >= 200) wt(9, 1'b1, 0);
	endtask
	task automatic rd(input logic [7:0] a);
		int i;
		araddr <= a;
		arv <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
			if (arr) arv <= 1'b0;
		end while (!rv && i < 200);
		d = rdata;
		r = rresp;
		if (i >= 200) wt(9, 1'b1, 0);
	endtask

	initial begin
		{rst_n, want_on, other_oe, oc, oc2, lock, uv, trip, cool, awv, wv, arv} = '0;
		{bready, rready, awaddr, araddr, wdata, errors, checks} = '0;
		bready = 1'b1;
		rready = 1'b1;
		void'($urandom(32'h1ff629cf));
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rd(8'h04);
		chk_word("status", 32'h8, d);
		m = $urandom_range(31);
		wr(8'h0c, m);
		chk_word("mask resp", 32'h0, {30'h0, r});
		rd(8'h0c);
		chk_word("mask", m, d);
		wr(8'h10, 32'h1);
		chk_word("bad write", 32'h2, {30'h0, r});
		rd(8'h14);
		chk_word("bad read", 32'h2, {30'h0, r});
		chk_word("bad data", 32'h0, d);
		$display("test registers done");
		lock <= 1'b1;
		want_on <= 1'b1;
		repeat (20) @(posedge clock);
		chk_bit("switch locked", 1'b0, sw);
		lock <= 1'b0;
		wt(0, 1'b1, 20);
		repeat (600) @(posedge clock);
		chk_bit("ramp", 1'b1, gate inside {8'h01, 8'h02});
		wr(8'h00, 32'h1);
		wt(0, 1'b0, 20);
		@(posedge clock);
		chk_word("gate off", 32'h0, {24'h0, gate});
		wr(8'h00, 32'h0);
		wt(0, 1'b1, 20);
		$display("test lockout done");
		wr(8'h0c, 32'h1f);
		wr(8'h08, 32'h1f);
		oc <= 1'b1;
		wt(1, 1'b1, 20);
		chk_bit("plain limit", 1'b1, lim_lo);
		chk_bit("plain window", 1'b0, sec_lo);
		s = cyc;
		repeat (ms($urandom_range(20, 100))) @(posedge clock);
		oc2 <= 1'b1;
		repeat (6) @(posedge clock);
		chk_bit("clamp", 1'b1, lim);
		chk_bit("blank", 1'b0, foe);
		wt(1, 1'b0, ms(130));
		oc2 <= 1'b0;
		chk_bit("window", 1'b1, (cyc - s) inside {[ms(127):ms(129)]});
		wt(2, 1'b1, ms(2));
		chk_bit("limit", 1'b1, lim);
		chk_bit("line", 1'b0, fline);
		chk_bit("irq", 1'b1, irq);
		chk_bit("plain fault", 1'b1, foe_lo);
		rd(8'h08);
		chk_word("events", 32'h9, d);
		oc <= 1'b0;
		wt(3, 1'b0, 10);
		repeat (ms(20)) @(posedge clock);
		oc <= 1'b1;
		repeat (10) @(posedge clock);
		chk_bit("no rearm", 1'b0, sec);
		chk_bit("limit", 1'b1, lim);
		oc <= 1'b0;
		wt(3, 1'b0, 10);
		s = cyc;
		wt(2, 1'b0, ms(140));
		chk_bit("release", 1'b1, (cyc - s) inside {[ms(126):ms(129)]});
		wr(8'h08, 32'h1f);
		rd(8'h08);
		chk_word("cleared", 32'h0, d);
		chk_bit("irq off", 1'b0, irq);
		repeat (ms(2)) @(posedge clock);
		rd(8'h04);
		chk_bit("armed", 1'b1, d[lsfs_pkg::STAT_ARMED_BIT]);
		oc <= 1'b1;
		wt(1, 1'b1, 20);
		oc <= 1'b0;
		wt(1, 1'b0, ms(130));
		$display("test surge done");
		uv <= 1'b1;
		repeat (ms($urandom_range(10, 25))) @(posedge clock);
		uv <= 1'b0;
		repeat (10) @(posedge clock);
		chk_bit("short dip", 1'b1, sw);
		uv <= 1'b1;
		s = cyc;
		wt(0, 1'b0, ms(40));
		chk_bit("uv off", 1'b1, (cyc - s) inside {[ms(31):ms(33)]});
		s = cyc;
		wt(0, 1'b1, ms(140));
		chk_bit("uv retry", 1'b1, (cyc - s) inside {[ms(127):ms(129)]});
		wt(0, 1'b0, ms(40));
		uv <= 1'b0;
		wt(0, 1'b1, ms(140));
		$display("test undervoltage done");
		trip <= 1'b1;
		repeat (3) @(posedge clock);
		trip <= 1'b0;
		wt(0, 1'b0, 10);
		repeat (ms(30)) @(posedge clock);
		chk_bit("hot off", 1'b0, sw);
		chk_bit("plain blank", 1'b0, foe_lo);
		repeat (ms(3)) @(posedge clock);
		chk_bit("plain hot", 1'b1, foe_lo);
		wt(2, 1'b1, ms(130));
		cool <= 1'b1;
		repeat (3) @(posedge clock);
		cool <= 1'b0;
		wt(0, 1'b1, 10);
		wt(2, 1'b0, ms(130));
		chk_bit("plain release", 1'b0, foe_lo);
		$display("test thermal done");
		other_oe <= 1'b1;
		repeat (2) @(posedge clock);
		chk_bit("wired line", 1'b0, fline);
		other_oe <= 1'b0;
		want_on <= 1'b0;
		wt(0, 1'b0, 10);
		chk_bit("plain off", 1'b0, sw_lo);
		want_on <= 1'b1;
		wt(0, 1'b1, 10);
		chk_bit("plain on", 1'b1, sw_lo);
		$display("test enable done");
		wrap_up();
	end
endmodule
